// ==== include/uip_pkg.sv ====
// constants shared by the serial-port interrupt and parity control block
// assumes a 32-bit apb slave with one aligned word per register index
package uip_pkg;
    localparam int ADDR_W = 12;
    localparam int DIV_W = 16;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_BAUD = 8'hFA;
    localparam logic [7:0] IDX_ISTAT = 8'hFB;
    localparam logic [7:0] IDX_IMASK = 8'hFC;
    localparam logic [7:0] IDX_CTRL = 8'hFD;
    localparam logic [7:0] IDX_PEND = 8'hFE;
    localparam logic [ADDR_W-1:0] ADDR_BAUD = {2'h0, IDX_BAUD, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_ISTAT = {2'h0, IDX_ISTAT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IMASK = {2'h0, IDX_IMASK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PEND = {2'h0, IDX_PEND, 2'h0};

    // serial_control_reg fields
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_MCE = 5;
    localparam int CTL_RXEN = 4;
    localparam int CTL_TX9 = 3;
    localparam int CTL_RX9 = 2;
    localparam int CTL_RXIE = 1;
    localparam int CTL_TXIE = 0;

    // serial_pending_reg fields; interrupt status and mask share them except PND_PEN
    localparam int PND_PEN = 5;
    localparam int PND_RPE = 4;
    localparam int PND_RX = 1;
    localparam int PND_TX = 0;
    localparam logic [7:0] ISTAT_BITS = 8'h13;

    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_8BIT = 2'h1;

    // whole frame lengths; uart modes count start and stop bits, shift mode has none
    localparam logic [3:0] LEN_SHIFT = 4'h8;
    localparam logic [3:0] LEN_8BIT = 4'hA;
    localparam logic [3:0] LEN_9BIT = 4'hB;

    localparam logic [3:0] FIRST_BIT_IDX = 4'h0;
    localparam logic [3:0] NINTH_BIT_IDX = 4'h8;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;

    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] BAUD_RST = 16'h0000;
endpackage

// ==== hdl/uip_baud_gen.sv ====
// baud tick generator: sixteen sample ticks per bit
// assumes the divisor comes from a register on the same clock
`timescale 1ns/1ps
module uip_baud_gen #(
    parameter int DIV_W = uip_pkg::DIV_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [DIV_W-1:0] divisor,
    output logic sample_tick,
    output logic bit_tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [3:0] sub;
        logic sample;
        logic bit_t;
    } uip_baud_s;

    uip_baud_s q;
    uip_baud_s next_q;

    // rate is pclk / (16 * (divisor + 1))
    always_comb
    begin
        next_q = q;
        next_q.sample = 1'b0;
        next_q.bit_t = 1'b0;
        if (q.cnt >= divisor)
        begin
            next_q.cnt = '0;
            next_q.sample = 1'b1;
            next_q.sub = q.sub + 4'h1;
            next_q.bit_t = (q.sub == uip_pkg::OVERSAMPLE_LAST);
        end
        else
        begin
            next_q.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign sample_tick = q.sample;
    assign bit_tick = q.bit_t;

    chk_bit_on_sample: assert property (
        @(posedge pclk) disable iff (!presetn)
        bit_tick |-> sample_tick && $past(q.sub) == uip_pkg::OVERSAMPLE_LAST)
    else $error("bit tick without sixteenth sample");
endmodule

// ==== hdl/uip_serial_ctrl.sv ====
// serial port interrupt, address filter and parity control with apb access
// assumes the shifter reports bits, frame ends and stop validity on pclk
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module uip_serial_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [uip_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_bit_valid,
    input wire logic [3:0] rx_bit_idx,
    input wire logic rx_bit_val,
    input wire logic rx_done,
    input wire logic rx_stop_ok,
    input wire logic rx_ninth,
    input wire logic tx_done,
    input wire logic [7:0] tx_data,
    output logic tx_ninth,
    output logic [3:0] frame_len,
    output logic [1:0] mode,
    output logic rx_enable,
    output logic sample_tick,
    output logic bit_tick,
    output logic rx_irq_req,
    output logic tx_irq_req,
    output logic irq
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] baud;
        logic par_on;
        logic rx_parity_fault;
        logic rx_pend;
        logic tx_pend;
        logic [7:0] istat;
        logic [7:0] imask;
        logic acc;
        logic tx9;
        logic [3:0] flen;
        logic [31:0] rdata;
    } uip_state_s;

    uip_state_s q;
    uip_state_s next_q;

    logic wr_access;
    logic rd_setup;
    logic hit_ctrl;
    logic hit_pend;
    logic hit_baud;
    logic hit_istat;
    logic hit_imask;
    logic hit_any;
    logic mode9;
    logic mode8;
    logic multiproc_filter_en;
    logic rx_block;
    logic rx_accept;
    logic ninth_strobe;
    logic rpe_check;
    logic [7:0] ev;

    assign hit_ctrl = (paddr == uip_pkg::ADDR_CTRL);
    assign hit_pend = (paddr == uip_pkg::ADDR_PEND);
    assign hit_baud = (paddr == uip_pkg::ADDR_BAUD);
    assign hit_istat = (paddr == uip_pkg::ADDR_ISTAT);
    assign hit_imask = (paddr == uip_pkg::ADDR_IMASK);
    assign hit_any = hit_ctrl | hit_pend | hit_baud | hit_istat | hit_imask;
    assign wr_access = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    // the upper mode bit alone selects nine-bit mode
    assign mode9 = q.ctrl[uip_pkg::CTL_MODE_HI];
    assign mode8 = (q.ctrl[uip_pkg::CTL_MODE_HI:uip_pkg::CTL_MODE_LO]
        == uip_pkg::MODE_8BIT);
    assign multiproc_filter_en = q.ctrl[uip_pkg::CTL_MCE];

    // address filter
    // shift mode ignores the filter; software must keep it off
    assign rx_block = multiproc_filter_en & ((mode9 & ~rx_ninth) | (mode8 & ~rx_stop_ok));
    assign rx_accept = rx_done & ~rx_block;

    assign ninth_strobe = rx_bit_valid & mode9
        & (rx_bit_idx == uip_pkg::NINTH_BIT_IDX);
    // even check expects an even count of ones over data and parity
    assign rpe_check = q.acc ^ rx_bit_val ^ q.ctrl[uip_pkg::CTL_RX9];

    always_comb
    begin
        next_q = q;
        ev = '0;

        // software writes land at the access edge; hardware sets follow
        if (wr_access && hit_ctrl)
        begin
            next_q.ctrl = pwdata[7:0];
        end
        if (wr_access && hit_baud)
        begin
            next_q.baud = pwdata[15:0];
        end
        if (wr_access && hit_imask)
        begin
            next_q.imask = pwdata[7:0] & uip_pkg::ISTAT_BITS;
        end
        if (wr_access && hit_istat)
        begin
            next_q.istat = q.istat & ~pwdata[7:0];
        end
        if (wr_access && hit_pend)
        begin
            next_q.par_on = pwdata[uip_pkg::PND_PEN];
            next_q.rx_parity_fault = pwdata[uip_pkg::PND_RPE];
            next_q.rx_pend = q.rx_pend & pwdata[uip_pkg::PND_RX];
            next_q.tx_pend = q.tx_pend & pwdata[uip_pkg::PND_TX];
        end

        // running parity of the eight data bits
        if (rx_bit_valid)
        begin
            if (rx_bit_idx == uip_pkg::FIRST_BIT_IDX)
            begin
                next_q.acc = rx_bit_val;
            end
            else if (rx_bit_idx < uip_pkg::NINTH_BIT_IDX)
            begin
                next_q.acc = q.acc ^ rx_bit_val;
            end
        end

        if (ninth_strobe)
        begin
            if (q.par_on)
            begin
                next_q.rx_parity_fault = rpe_check;
                ev[uip_pkg::PND_RPE] = rpe_check;
            end
            else
            begin
                next_q.ctrl[uip_pkg::CTL_RX9] = rx_bit_val;
            end
        end

        // completion sets pending; set beats a same-cycle clear
        if (rx_accept)
        begin
            next_q.rx_pend = 1'b1;
            ev[uip_pkg::PND_RX] = q.ctrl[uip_pkg::CTL_RXIE];
        end
        if (tx_done)
        begin
            next_q.tx_pend = 1'b1;
            ev[uip_pkg::PND_TX] = q.ctrl[uip_pkg::CTL_TXIE];
        end
        next_q.istat = next_q.istat | ev;

        if (mode9 && q.par_on)
        begin
            next_q.tx9 = (^tx_data) ^ q.ctrl[uip_pkg::CTL_TX9];
        end
        else
        begin
            next_q.tx9 = q.ctrl[uip_pkg::CTL_TX9];
        end

        // frame length; start and stop counted except in shift mode
        if (mode9)
        begin
            next_q.flen = uip_pkg::LEN_9BIT;
        end
        else if (mode8)
        begin
            next_q.flen = uip_pkg::LEN_8BIT;
        end
        else
        begin
            next_q.flen = uip_pkg::LEN_SHIFT;
        end

        // read data is fetched in setup so it is stable for the access
        if (rd_setup)
        begin
            next_q.rdata = '0;
            if (hit_ctrl)
            begin
                next_q.rdata[7:0] = q.ctrl;
            end
            else if (hit_baud)
            begin
                next_q.rdata[15:0] = q.baud;
            end
            else if (hit_istat)
            begin
                next_q.rdata[7:0] = q.istat;
            end
            else if (hit_imask)
            begin
                next_q.rdata[7:0] = q.imask;
            end
            else if (hit_pend)
            begin
                next_q.rdata[uip_pkg::PND_PEN] = q.par_on;
                next_q.rdata[uip_pkg::PND_RPE] = q.rx_parity_fault;
                next_q.rdata[uip_pkg::PND_RX] = q.rx_pend;
                next_q.rdata[uip_pkg::PND_TX] = q.tx_pend;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    uip_baud_gen #(
        .DIV_W(uip_pkg::DIV_W)
    ) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .divisor(q.baud),
        .sample_tick(sample_tick),
        .bit_tick(bit_tick)
    );

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata = q.rdata;
    assign tx_ninth = q.tx9;
    assign frame_len = q.flen;
    assign mode = q.ctrl[uip_pkg::CTL_MODE_HI:uip_pkg::CTL_MODE_LO];
    assign rx_enable = q.ctrl[uip_pkg::CTL_RXEN];
    assign tx_irq_req = q.tx_pend & q.ctrl[uip_pkg::CTL_TXIE];
    assign rx_irq_req = q.rx_pend & q.ctrl[uip_pkg::CTL_RXIE];
    assign irq = |(q.istat & q.imask);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_pend;
    logic wr_ctrl;
    assign wr_pend = wr_access & hit_pend;
    assign wr_ctrl = wr_access & hit_ctrl;

    // a request may drop a cycle later only through a software write
    chk_tx_gate: assert property (
        tx_done && q.ctrl[uip_pkg::CTL_TXIE] && !wr_ctrl
        |=> tx_irq_req
        ##1 (tx_irq_req || $past(wr_pend) || $past(wr_ctrl)))
    else $error("enabled transmit completion did not raise request");

    chk_ninth_filter: assert property (
        rx_done && mode9 && multiproc_filter_en && !rx_ninth && !q.rx_pend
        |=> !q.rx_pend)
    else $error("ninth-bit-zero frame set receive pending");

    chk_stop_filter: assert property (
        rx_done && mode8 && multiproc_filter_en && !rx_stop_ok && !q.rx_pend
        |=> !q.rx_pend && !$rose(q.istat[uip_pkg::PND_RX]))
    else $error("frame without stop set receive pending");

    chk_frame_len: assert property (
        mode8 && !(wr_access && hit_ctrl) |=> frame_len == uip_pkg::LEN_8BIT)
    else $error("eight-bit frame length wrong");

    chk_pen_write: assert property (
        wr_pend |=> q.par_on == $past(pwdata[uip_pkg::PND_PEN]))
    else $error("parity enable did not take written value");

    chk_rpe_mode: assert property (
        !mode9 && !wr_pend |=> $stable(q.rx_parity_fault))
    else $error("parity fault changed outside nine-bit mode");

    chk_rpe_update: assert property (
        ninth_strobe && q.par_on && !wr_pend
        |=> q.rx_parity_fault == $past(rpe_check)
        && (q.istat[uip_pkg::PND_RPE] || !$past(rpe_check)))
    else $error("parity fault not refreshed at ninth bit");

    chk_pend_clear: assert property (
        wr_pend && !pwdata[uip_pkg::PND_RX] && !rx_accept |=> !q.rx_pend)
    else $error("writing zero did not clear receive pending");

    chk_pend_set: assert property (
        (rx_accept || (q.rx_pend && wr_pend && pwdata[uip_pkg::PND_RX]))
        |=> q.rx_pend)
    else $error("receive pending lost on set or write one");

    chk_ninth_tx: assert property (
        mode9 && !q.par_on && !(wr_access && hit_ctrl)
        |=> tx_ninth == $past(q.ctrl[uip_pkg::CTL_TX9]))
    else $error("ninth transmit bit not taken from control");

    chk_rx_gate: assert property (
        rx_accept && q.ctrl[uip_pkg::CTL_RXIE] && !wr_ctrl
        |=> rx_irq_req)
    else $error("enabled receive completion did not raise request");

    chk_tx_pend_set: assert property (
        tx_done |=> q.tx_pend)
    else $error("transmit completion did not set pending");

    chk_tx_parity: assert property (
        mode9 && q.par_on && !wr_ctrl
        |=> tx_ninth == ((^$past(tx_data)) ^ $past(q.ctrl[uip_pkg::CTL_TX9])))
    else $error("generated transmit parity wrong");

    // capture wins over a software write in the same cycle
    chk_rx9_capture: assert property (
        ninth_strobe && !q.par_on
        |=> q.ctrl[uip_pkg::CTL_RX9] == $past(rx_bit_val))
    else $error("ninth received bit not captured");
endmodule

// ==== verification/uip_shift_model.sv ====
// shifter-side model: feeds received bits, frame ends and tx completions
// assumes the caller runs its tasks from one process on pclk
`timescale 1ns/1ps
module uip_shift_model (
    input wire logic pclk,
    output logic rx_bit_valid,
    output logic [3:0] rx_bit_idx,
    output logic rx_bit_val,
    output logic rx_done,
    output logic rx_stop_ok,
    output logic rx_ninth,
    output logic tx_done,
    output logic [7:0] tx_data
);
    initial
    begin
        rx_bit_valid = 1'b0;
        rx_bit_idx = 4'h0;
        rx_bit_val = 1'b0;
        rx_done = 1'b0;
        rx_stop_ok = 1'b0;
        rx_ninth = 1'b0;
        tx_done = 1'b0;
        tx_data = 8'h00;
    end

    // data bits only, start and stop stay implicit
    task automatic rx_frame(input logic [8:0] bits, input logic stop,
                            input int nbits);
        int i;
        for (i = 0; i < nbits; i++)
        begin
            @(posedge pclk);
            rx_bit_valid <= 1'b1;
            rx_bit_idx <= i[3:0];
            rx_bit_val <= bits[i];
        end
        @(posedge pclk);
        rx_bit_valid <= 1'b0;
        rx_bit_val <= ~rx_bit_val;
        rx_done <= 1'b1;
        rx_stop_ok <= stop;
        rx_ninth <= bits[8];
        @(posedge pclk);
        // stale qualifiers are inverted so nothing leans on old values
        rx_done <= 1'b0;
        rx_stop_ok <= ~stop;
        rx_ninth <= ~bits[8];
    endtask

    task automatic tx_frame(input logic [7:0] data);
        @(posedge pclk);
        tx_data <= data;
        tx_done <= 1'b1;
        @(posedge pclk);
        tx_done <= 1'b0;
    endtask
endmodule

// ==== verification/uart_interrupt_parity_control_tb_top.sv ====
// self-checking bench for the serial interrupt and parity control block
// assumes zero-wait apb slave and the shifter model beside it
`timescale 1ns/1ps
module uart_interrupt_parity_control_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rbv, rbval, rdone, rstop, rninth, tdone, tx_ninth;
    logic [3:0] ridx, frame_len;
    logic [7:0] tdata;
    logic [1:0] mode;
    logic rx_enable, sample_tick, bit_tick, rx_irq_req, tx_irq_req, irq;
    logic err;
    int err_total = 0;
    int tests_run = 0;
    int ns, nb, k;
    logic [7:0] tv_pend [4] = '{8'h20, 8'h20, 8'h00, 8'h00};
    logic [7:0] tv_ctrl [4] = '{8'h80, 8'h88, 8'h88, 8'h80};
    logic tv_nin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    uip_serial_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_bit_valid(rbv), .rx_bit_idx(ridx), .rx_bit_val(rbval),
        .rx_done(rdone), .rx_stop_ok(rstop), .rx_ninth(rninth),
        .tx_done(tdone), .tx_data(tdata), .tx_ninth(tx_ninth),
        .frame_len(frame_len), .mode(mode), .rx_enable(rx_enable),
        .sample_tick(sample_tick), .bit_tick(bit_tick),
        .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req), .irq(irq));
    uip_shift_model model (.pclk(pclk), .rx_bit_valid(rbv),
        .rx_bit_idx(ridx), .rx_bit_val(rbval), .rx_done(rdone),
        .rx_stop_ok(rstop), .rx_ninth(rninth), .tx_done(tdone),
        .tx_data(tdata));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp)
        begin
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
            err_total++;
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h0, d});
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp,
                        input string what);
        apb(a, 1'b0, 32'h0);
        check(rd, {24'h0, exp}, what);
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_total++;
        end_sim;
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tick(4);
        presetn <= 1'b1;
        rchk(uip_pkg::ADDR_PEND, 8'h00, "pend reset");
        rchk(uip_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
        rchk(uip_pkg::ADDR_ISTAT, 8'h00, "istat reset");
        rchk(uip_pkg::ADDR_IMASK, 8'h00, "imask reset");
        rchk(uip_pkg::ADDR_BAUD, 8'h00, "baud reset");
        rchk(12'h000, 8'h00, "unmapped read");
        check({31'h0, err}, 32'h1, "unmapped slverr");
        $display("test reset done");

        for (k = 0; k < 4; k++)
        begin
            wr(uip_pkg::ADDR_CTRL, {k[1:0], 1'b0, k[0], 4'h0});
            tick(2);
            check({30'h0, mode}, k, "mode field");
            check({31'h0, rx_enable}, {31'h0, k[0]}, "rx enable");
            check({28'h0, frame_len}, (k == 0) ? 8 : (k == 1) ? 10 : 11,
                  "frame length");
        end
        $display("test modes done");

        wr(uip_pkg::ADDR_CTRL, 8'h40);
        model.tx_frame(8'h55);
        tick(2);
        check({31'h0, tx_irq_req}, 32'h0, "tx req blocked");
        rchk(uip_pkg::ADDR_PEND, 8'h01, "tx pend set");
        wr(uip_pkg::ADDR_CTRL, 8'h41);
        tick(2);
        check({31'h0, tx_irq_req}, 32'h1, "tx req allowed");
        wr(uip_pkg::ADDR_PEND, 8'h01);
        rchk(uip_pkg::ADDR_PEND, 8'h01, "write one keeps");
        wr(uip_pkg::ADDR_PEND, 8'h00);
        rchk(uip_pkg::ADDR_PEND, 8'h00, "write zero clears");
        check({31'h0, tx_irq_req}, 32'h0, "tx req cleared");
        model.tx_frame(8'h00);
        tick(2);
        check({31'h0, tx_irq_req}, 32'h1, "tx req on done");
        rchk(uip_pkg::ADDR_ISTAT, 8'h01, "istat tx");
        wr(uip_pkg::ADDR_ISTAT, 8'h01);
        wr(uip_pkg::ADDR_PEND, 8'h00);
        rchk(uip_pkg::ADDR_ISTAT, 8'h00, "istat tx cleared");
        rchk(uip_pkg::ADDR_PEND, 8'h00, "tx pend cleared");
        $display("test tx pending done");

        wr(uip_pkg::ADDR_IMASK, 8'h02);
        wr(uip_pkg::ADDR_CTRL, 8'h62);
        model.rx_frame(9'h0A5, 1'b0, 8);
        tick(2);
        rchk(uip_pkg::ADDR_PEND, 8'h00, "bad stop filtered");
        check({31'h0, irq}, 32'h0, "no irq filtered");
        model.rx_frame(9'h0A5, 1'b1, 8);
        tick(2);
        rchk(uip_pkg::ADDR_PEND, 8'h02, "rx pend set");
        check({31'h0, rx_irq_req}, 32'h1, "rx req allowed");
        check({31'h0, irq}, 32'h1, "irq raised");
        rchk(uip_pkg::ADDR_ISTAT, 8'h02, "istat rx");
        wr(uip_pkg::ADDR_ISTAT, 8'h02);
        tick(1);
        check({31'h0, irq}, 32'h0, "irq cleared");
        wr(uip_pkg::ADDR_CTRL, 8'h60);
        tick(2);
        check({31'h0, rx_irq_req}, 32'h0, "rx req blocked");
        wr(uip_pkg::ADDR_PEND, 8'h00);
        $display("test rx filter 8 done");

        wr(uip_pkg::ADDR_IMASK, 8'h00);
        wr(uip_pkg::ADDR_CTRL, 8'hA0);
        model.rx_frame(9'h0A5, 1'b1, 9);
        tick(2);
        rchk(uip_pkg::ADDR_PEND, 8'h00, "ninth zero filtered");
        model.rx_frame(9'h1A5, 1'b1, 9);
        tick(2);
        rchk(uip_pkg::ADDR_PEND, 8'h02, "ninth one passes");
        rchk(uip_pkg::ADDR_CTRL, 8'hA4, "ninth captured");
        check({31'h0, irq}, 32'h0, "irq masked off");
        $display("test rx filter 9 done");

        wr(uip_pkg::ADDR_PEND, 8'h20);
        wr(uip_pkg::ADDR_CTRL, 8'h80);
        model.rx_frame(9'h001, 1'b1, 9);
        tick(2);
        rchk(uip_pkg::ADDR_PEND, 8'h32, "parity fault");
        rchk(uip_pkg::ADDR_ISTAT, 8'h10, "parity fault status");
        wr(uip_pkg::ADDR_PEND, 8'h20);
        model.rx_frame(9'h101, 1'b1, 9);
        tick(2);
        rchk(uip_pkg::ADDR_PEND, 8'h22, "parity good");
        // fault preset so an update outside nine-bit mode would show
        wr(uip_pkg::ADDR_PEND, 8'h30);
        wr(uip_pkg::ADDR_CTRL, 8'h40);
        model.rx_frame(9'h001, 1'b1, 8);
        tick(2);
        rchk(uip_pkg::ADDR_PEND, 8'h32, "no parity in 8 bit");
        $display("test parity rx done");

        model.tx_frame(8'h07);
        for (k = 0; k < 4; k++)
        begin
            wr(uip_pkg::ADDR_PEND, tv_pend[k]);
            wr(uip_pkg::ADDR_CTRL, tv_ctrl[k]);
            tick(2);
            check({31'h0, tx_ninth}, {31'h0, tv_nin[k]}, "tx ninth");
        end
        $display("test tx ninth done");

        wr(uip_pkg::ADDR_BAUD, 8'h03);
        tick(2);
        ns = 0;
        nb = 0;
        repeat (128)
        begin
            @(posedge pclk);
            if (sample_tick === 1'b1)
                ns++;
            if (bit_tick === 1'b1)
                nb++;
        end
        check(ns, 32, "sample ticks");
        check(nb, 2, "bit ticks");
        $display("test baud done");
        end_sim;
    end
endmodule
